// file: sfl_flash.sv
// module: single-line-instruction serial flash device with register port
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - instruction byte always on io_line0; address and data on 1, 2 or 4 lines.
// - fast read dummy count from volatile bits 7:4 or nonvolatile bits 15:12.
// - page write programs up to 256 bytes in one page, only 1 to 0.
// - two-line program takes data on two lines; extended one also address.
// - four-line program takes data on four lines; extended one also address.
// - erase to FFh per boot subsector, per sector, or whole array.
// - busy flag shows cycle in progress; controller flag is its inverse.
// - flag register holds program error and erase error bits.
// - selected means active; deselected stays active until cycles end, then standby.
// - pause suspends the interface but never aborts a running cycle.
// - pause entered only while chip select is low.
// - pause starts and ends on pin edges, deferred until clock low.
// - while paused io_line1 floats, io_line0 and clock ignored.
// - deselect during pause resets interface; master releases pause before reselect.
// - reset pin low enters reset, may corrupt cycles; wait before reselect.
// - reset pulse clears every sector lock bit.
// - pause or reset inactive while io_line3 carries quad data.
// - volatile enhanced bit 4 low disables the pause or reset pin function.
// - sample on rising clock edge, drive on falling; modes 0 and 3.
module sfl_flash #(
  parameter int MEM_AW = 16,
  parameter int SEC_AW = 12,
  parameter int SUB_AW = 10
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic FL_CS_N,
  input wire logic FL_SCK,
  input wire logic FL_IO0_I,
  output logic FL_IO0_O,
  output logic FL_IO0_OE,
  input wire logic FL_IO1_I,
  output logic FL_IO1_O,
  output logic FL_IO1_OE,
  input wire logic FL_IO2_I,
  output logic FL_IO2_O,
  output logic FL_IO2_OE,
  input wire logic FL_IO3_I,
  output logic FL_IO3_O,
  output logic FL_IO3_OE,
  input wire logic [sfl_pkg::RA_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic FL_STANDBY
);
  import sfl_pkg::*;

  localparam int NSEC = 2 ** (MEM_AW - SEC_AW);
  localparam logic [MEM_AW:0] LEN_SUB = (MEM_AW + 1)'(1) << SUB_AW;
  localparam logic [MEM_AW:0] LEN_SEC = (MEM_AW + 1)'(1) << SEC_AW;
  localparam logic [MEM_AW:0] LEN_ALL = (MEM_AW + 1)'(1) << MEM_AW;
  localparam logic [7:0] RST_SEL_CNT = 8'(RST_SEL_CYC);

  function automatic logic [23:0] shin(input logic [23:0] sh, input logic [2:0] w,
                                       input logic [3:0] d);
    shin = (w == 3'd1) ? {sh[22:0], d[0]} : (w == 3'd2) ? {sh[21:0], d[1:0]} : {sh[19:0], d};
  endfunction

  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [2:0] w);
    lane_out = (w == 3'd1) ? {2'b00, b[7], 1'b0} : (w == 3'd2) ? {2'b00, b[7:6]} : b[7:4];
  endfunction

  logic [7:0] mem [0:(2**MEM_AW)-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic [5:0] s1_q, s2_q;
  logic sck3_q, cs3_q;
  logic paused_q, stby_q;
  logic [7:0] rst_cnt_q;
  sfl_state_t st_q;
  sfl_cycle_t cy_q;
  logic [4:0] cnt_q;
  logic [23:0] sh_q;
  logic [2:0] aw_q, dw_q;
  logic dmy_en_q, pg_q, ws_q, wc_q, rs_q, fl_q, quad_q;
  logic [1:0] er_q;
  logic [MEM_AW-1:0] ra_q, wa_q;
  logic [MEM_AW:0] wleft_q;
  logic [8:0] nb_q;
  logic [7:0] bi_q, pi_q, osh_q;
  logic [3:0] ob_cnt_q, io_o_q;
  logic wel_q, perr_q, eerr_q;
  logic [7:0] vol_cfg_q, vol_enh_q, ctrl_q;
  logic [15:0] nv_cfg_q;
  logic [NSEC-1:0] lock_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is read
  logic cs_n_s, sck_s, sck_rise, sck_fall, cs_rise;
  logic [3:0] io_s;
  assign cs_n_s = s2_q[0];
  assign sck_s = s2_q[1];
  assign io_s = s2_q[5:2];
  assign sck_rise = sck_s & ~sck3_q;
  assign sck_fall = ~sck_s & sck3_q;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      sck3_q <= 1'b0;
      cs3_q <= 1'b1;
    end
    else if (CLK_EN)
    begin
      s1_q <= {FL_IO3_I, FL_IO2_I, FL_IO1_I, FL_IO0_I, FL_SCK, FL_CS_N};
      s2_q <= s1_q;
      sck3_q <= sck_s;
      cs3_q <= cs_n_s;
    end

  ////////////////////////////////////////////////////////////////////////////
  // shared pause / reset pin
  logic busy, pin_fn_on, pause_req, rst_req, sel_ok, active, rise, fall;
  assign busy = (cy_q != CY_IDLE);
  // quad instructions own io_line3 as data
  assign pin_fn_on = vol_enh_q[ENH_PIN_EN] & ~(quad_q & ~cs_n_s);
  assign pause_req = pin_fn_on & ~ctrl_q[CTRL_RSTFN] & ~io_s[3] & ~cs_n_s;
  assign rst_req = pin_fn_on & ctrl_q[CTRL_RSTFN] & ~io_s[3];
  assign sel_ok = (rst_cnt_q == 8'h00) & ~rst_req;
  assign active = ~cs_n_s & sel_ok & ~paused_q;
  assign rise = sck_rise & active;
  assign fall = sck_fall & active;
  assign cs_rise = cs_n_s & ~cs3_q & sel_ok & ~paused_q;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      paused_q <= 1'b0;
      rst_cnt_q <= 8'h00;
      stby_q <= 1'b1;
    end
    else if (CLK_EN)
    begin
      // pause pin edges only take effect while the clock is low
      if (cs_n_s)
        paused_q <= 1'b0;
      else if (~sck_s)
        paused_q <= pause_req;
      rst_cnt_q <= rst_req ? RST_SEL_CNT : (sel_ok ? 8'h00 : rst_cnt_q - 8'h01);
      // launch edge: not busy yet
      stby_q <= cs_n_s & ~cs_rise & ~busy;
    end

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode of the byte completing on this edge
  logic [23:0] nsh;
  logic [4:0] ncnt;
  logic [2:0] w_in, c_aw, c_dw;
  logic c_ok, c_dmy, c_out, c_pg, c_ws, c_wc, c_rs, c_fl, c_q;
  logic [1:0] c_er;
  assign w_in = (st_q == ST_ADDR) ? aw_q : (st_q == ST_DIN) ? dw_q : 3'd1;
  assign nsh = shin(sh_q, w_in, io_s);
  assign ncnt = cnt_q + {2'b00, w_in};

  always_comb
  begin
    c_ok = 1'b1;
    c_aw = 3'd0;
    c_dw = 3'd1;
    c_dmy = 1'b0;
    c_out = 1'b0;
    c_pg = 1'b0;
    c_er = 2'd0;
    c_ws = 1'b0;
    c_wc = 1'b0;
    c_rs = 1'b0;
    c_fl = 1'b0;
    c_q = 1'b0;
    case (nsh[7:0])
      OP_READ: begin c_aw = 3'd1; c_out = 1'b1; end
      OP_FREAD: begin c_aw = 3'd1; c_out = 1'b1; c_dmy = 1'b1; end
      OP_DOREAD: begin c_aw = 3'd1; c_dw = 3'd2; c_out = 1'b1; c_dmy = 1'b1; end
      OP_DIOREAD: begin c_aw = 3'd2; c_dw = 3'd2; c_out = 1'b1; c_dmy = 1'b1; end
      OP_QOREAD: begin c_aw = 3'd1; c_dw = 3'd4; c_out = 1'b1; c_dmy = 1'b1; c_q = 1'b1; end
      OP_QIOREAD: begin c_aw = 3'd4; c_dw = 3'd4; c_out = 1'b1; c_dmy = 1'b1; c_q = 1'b1; end
      OP_PGW: begin c_aw = 3'd1; c_pg = 1'b1; end
      OP_P2D: begin c_aw = 3'd1; c_dw = 3'd2; c_pg = 1'b1; end
      OP_P2AD: begin c_aw = 3'd2; c_dw = 3'd2; c_pg = 1'b1; end
      OP_P4D: begin c_aw = 3'd1; c_dw = 3'd4; c_pg = 1'b1; c_q = 1'b1; end
      OP_P4AD: begin c_aw = 3'd4; c_dw = 3'd4; c_pg = 1'b1; c_q = 1'b1; end
      OP_ESMALL: begin c_aw = 3'd1; c_er = 2'd1; end
      OP_EBLK: begin c_aw = 3'd1; c_er = 2'd2; end
      OP_EALL: c_er = 2'd3;
      OP_WLSET: c_ws = 1'b1;
      OP_WLCLR: c_wc = 1'b1;
      OP_RSTAT: begin c_out = 1'b1; c_rs = 1'b1; end
      OP_RFLAG: begin c_out = 1'b1; c_fl = 1'b1; end
      default: c_ok = 1'b0;
    endcase
  end

  // dummy count: volatile field first, nonvolatile when it is 0
  logic [3:0] dmy_raw, dmy_cyc;
  assign dmy_raw = (vol_cfg_q[VOL_DUMMY_LO +: 4] != 4'h0) ? vol_cfg_q[VOL_DUMMY_LO +: 4]
                                                         : nv_cfg_q[NV_DUMMY_LO +: 4];
  assign dmy_cyc = (dmy_raw == 4'h0 || dmy_raw == 4'hf) ? DUMMY_DEF : dmy_raw;

  logic [7:0] stat_b, flag_b, src_byte, cur_byte;
  assign stat_b = {6'h00, wel_q, busy};
  assign flag_b = {~busy, 1'b0, eerr_q, perr_q, 4'h0};
  assign src_byte = rs_q ? stat_b : (fl_q ? flag_b : mem[ra_q]);
  assign cur_byte = (ob_cnt_q == 4'h0) ? src_byte : osh_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial front end: inputs on rising edges, outputs on falling edges
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      st_q <= ST_CMD;
      cnt_q <= 5'd0;
      sh_q <= 24'h00_0000;
      {aw_q, dw_q} <= {3'd0, 3'd1};
      {dmy_en_q, pg_q, ws_q, wc_q, rs_q, fl_q, quad_q, er_q} <= 9'h000;
      ra_q <= '0;
      nb_q <= 9'h000;
      bi_q <= 8'h00;
      osh_q <= 8'h00;
      ob_cnt_q <= 4'h0;
      io_o_q <= 4'h0;
    end
    else if (CLK_EN)
    begin
      if (cs_n_s | ~sel_ok)
      begin
        // deselect or reset: interface back to its start
        st_q <= ST_CMD;
        cnt_q <= 5'd0;
        {dmy_en_q, pg_q, ws_q, wc_q, rs_q, fl_q, quad_q, er_q} <= 9'h000;
        nb_q <= 9'h000;
        bi_q <= 8'h00;
        ob_cnt_q <= 4'h0;
      end
      else if (rise)
      begin
        sh_q <= nsh;
        case (st_q)
          ST_CMD:
            if (ncnt == 5'd8)
            begin
              cnt_q <= 5'd0;
              {aw_q, dw_q, dmy_en_q, pg_q, er_q} <= {c_aw, c_dw, c_dmy, c_pg, c_er};
              {ws_q, wc_q, rs_q, fl_q, quad_q} <= {c_ws, c_wc, c_rs, c_fl, c_q};
              // while a cycle runs only the polling reads are taken
              if (~c_ok | (busy & ~(c_rs | c_fl)))
                st_q <= ST_IGN;
              else if (c_aw != 3'd0)
                st_q <= ST_ADDR;
              else
                st_q <= c_out ? ST_DOUT : ST_DIN;
            end
            else
              cnt_q <= ncnt;
          ST_ADDR:
            if (ncnt == 5'(ADDR_BITS))
            begin
              cnt_q <= 5'd0;
              ra_q <= nsh[MEM_AW-1:0];
              bi_q <= 8'h00;
              if (pg_q | (er_q != 2'd0))
                st_q <= ST_DIN;
              else
                st_q <= (dmy_en_q & (dmy_cyc != 4'h0)) ? ST_DUMMY : ST_DOUT;
            end
            else
              cnt_q <= ncnt;
          ST_DUMMY:
            if (cnt_q + 5'd1 == {1'b0, dmy_cyc})
            begin
              cnt_q <= 5'd0;
              st_q <= ST_DOUT;
            end
            else
              cnt_q <= cnt_q + 5'd1;
          ST_DIN:
            if (ncnt == 5'd8)
            begin
              cnt_q <= 5'd0;
              bi_q <= bi_q + 8'h01;
              if (nb_q != 9'(PAGE_BYTES))
                nb_q <= nb_q + 9'h001;
            end
            else
              cnt_q <= ncnt;
          ST_DOUT, ST_IGN: cnt_q <= cnt_q;
          default: st_q <= ST_IGN;
        endcase
      end
      else if (fall && st_q == ST_DOUT)
      begin
        io_o_q <= lane_out(cur_byte, dw_q);
        osh_q <= cur_byte << dw_q;
        ob_cnt_q <= ((ob_cnt_q == 4'h0) ? 4'h8 : ob_cnt_q) - {1'b0, dw_q};
        if (ob_cnt_q == 4'h0 && ~rs_q && ~fl_q)
          ra_q <= ra_q + 1'b1;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // launch of internal cycles at deselect on a byte boundary
  logic at_end, go_pg, go_er, pg_lock, er_bad;
  logic [NSEC-1:0] sec_bit;
  assign at_end = cs_rise & (st_q == ST_DIN) & (cnt_q == 5'd0);
  assign sec_bit = NSEC'(1) << ra_q[MEM_AW-1:SEC_AW];
  assign go_pg = at_end & pg_q & (nb_q != 9'h000) & wel_q;
  assign go_er = at_end & (er_q != 2'd0) & wel_q;
  assign pg_lock = |(lock_q & sec_bit);
  assign er_bad = (er_q == 2'd3) ? (|lock_q)
                : pg_lock | ((er_q == 2'd1) & (32'(ra_q[MEM_AW-1:SEC_AW]) >= BOOT_SECS));

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      cy_q <= CY_IDLE;
      wa_q <= '0;
      wleft_q <= '0;
      pi_q <= 8'h00;
      wel_q <= 1'b0;
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      // error flags: a new failure wins over a software clear
      perr_q <= (go_pg & pg_lock) | (rst_req & (cy_q == CY_PROG))
              | (perr_q & ~(REG_WR & (REG_ADDR == RA_FLAG) & REG_WDATA[FL_PERR]));
      eerr_q <= (go_er & er_bad) | (rst_req & (cy_q == CY_ERASE))
              | (eerr_q & ~(REG_WR & (REG_ADDR == RA_FLAG) & REG_WDATA[FL_EERR]));
      if (rst_req)
      begin
        cy_q <= CY_IDLE;
        wel_q <= 1'b0;
      end
      else if (go_pg | go_er)
      begin
        wel_q <= 1'b0;
        pi_q <= 8'h00;
        if (go_pg & ~pg_lock)
        begin
          cy_q <= CY_PROG;
          wa_q <= ra_q;
          wleft_q <= (MEM_AW + 1)'(nb_q);
        end
        else if (go_er & ~er_bad)
        begin
          cy_q <= CY_ERASE;
          case (er_q)
            2'd1: begin wa_q <= {ra_q[MEM_AW-1:SUB_AW], SUB_AW'(0)}; wleft_q <= LEN_SUB; end
            2'd2: begin wa_q <= {ra_q[MEM_AW-1:SEC_AW], SEC_AW'(0)}; wleft_q <= LEN_SEC; end
            default: begin wa_q <= '0; wleft_q <= LEN_ALL; end
          endcase
        end
      end
      else if (at_end & ws_q)
        wel_q <= 1'b1;
      else if (at_end & wc_q)
        wel_q <= 1'b0;
      else if (busy)
      begin
        // one byte per clock; selection and pause do not stop it
        wleft_q <= wleft_q - 1'b1;
        pi_q <= pi_q + 8'h01;
        if (cy_q == CY_PROG)
          wa_q <= {wa_q[MEM_AW-1:8], wa_q[7:0] + 8'h01};
        else
          wa_q <= wa_q + 1'b1;
        if (wleft_q == (MEM_AW + 1)'(1))
          cy_q <= CY_IDLE;
      end
    end

  // array and page buffer carry no reset
  always_ff @(posedge CLK_SYS)
  begin
    if (CLK_EN && busy && !rst_req)
      mem[wa_q] <= (cy_q == CY_PROG) ? (mem[wa_q] & pbuf[pi_q]) : 8'hff;
    if (CLK_EN && rise && st_q == ST_DIN && pg_q && ncnt == 5'd8 && ~cs_n_s && sel_ok)
      pbuf[bi_q] <= nsh[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  logic wr_vol, wr_nv, wr_enh, wr_ctrl, wr_lock;
  logic [31:0] rd_mux;
  assign wr_vol = REG_WR & (REG_ADDR == RA_VOL_CFG);
  assign wr_nv = REG_WR & (REG_ADDR == RA_NV_CFG);
  assign wr_enh = REG_WR & (REG_ADDR == RA_VOL_ENH);
  assign wr_ctrl = REG_WR & (REG_ADDR == RA_CTRL);
  assign wr_lock = REG_WR & (REG_ADDR == RA_LOCK);
  assign rd_mux = (REG_ADDR == RA_VOL_CFG) ? {24'h00_0000, vol_cfg_q}
                : (REG_ADDR == RA_NV_CFG) ? {16'h0000, nv_cfg_q}
                : (REG_ADDR == RA_VOL_ENH) ? {24'h00_0000, vol_enh_q}
                : (REG_ADDR == RA_CTRL) ? {24'h00_0000, ctrl_q}
                : (REG_ADDR == RA_LOCK) ? 32'(lock_q)
                : (REG_ADDR == RA_STAT) ? {24'h00_0000, stat_b | {5'h00, stby_q, 2'b00}}
                : (REG_ADDR == RA_FLAG) ? {24'h00_0000, flag_b} : 32'h0000_0000;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      vol_cfg_q <= VOL_CFG_RST;
      nv_cfg_q <= NV_CFG_RST;
      vol_enh_q <= VOL_ENH_RST;
      ctrl_q <= 8'h00;
      lock_q <= '0;
      rdata_q <= 32'h0000_0000;
    end
    else if (CLK_EN)
    begin
      if (wr_vol)
        vol_cfg_q <= REG_WDATA[7:0];
      if (wr_nv)
        nv_cfg_q <= REG_WDATA[15:0];
      if (wr_enh)
        vol_enh_q <= REG_WDATA[7:0];
      if (wr_ctrl)
        ctrl_q <= {7'h00, REG_WDATA[CTRL_RSTFN]};
      if (rst_req)
        lock_q <= '0;
      else if (wr_lock)
        lock_q <= REG_WDATA[NSEC-1:0];
      rdata_q <= REG_RD ? rd_mux : 32'h0000_0000;
    end

  ////////////////////////////////////////////////////////////////////////////
  // pins: io_line1 floats while paused or outside output phases
  logic drv;
  assign drv = (st_q == ST_DOUT) & active;
  assign FL_IO0_O = io_o_q[0];
  assign FL_IO1_O = io_o_q[1];
  assign FL_IO2_O = io_o_q[2];
  assign FL_IO3_O = io_o_q[3];
  assign FL_IO0_OE = drv & (dw_q != 3'd1);
  assign FL_IO1_OE = drv;
  assign FL_IO2_OE = drv & (dw_q == 3'd4);
  assign FL_IO3_OE = drv & (dw_q == 3'd4);
  assign REG_RDATA = rdata_q;
  assign FL_STANDBY = stby_q;
endmodule // sfl_flash
`default_nettype wire

// file: sfl_flash_sva.sv
// checker: port-level properties of the serial flash block
`timescale 1ns/100ps
`default_nettype none
module sfl_flash_chk
  import sfl_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic FL_CS_N,
  input wire logic FL_SCK,
  input wire logic FL_IO3_I,
  input wire logic FL_IO1_O,
  input wire logic FL_IO0_OE,
  input wire logic FL_IO1_OE,
  input wire logic [sfl_pkg::RA_W-1:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic FL_STANDBY
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  // pins pass a two-stage sync, so five cycles covers the lag
  sequence s_sel;
    !FL_CS_N [*5];
  endsequence
  sequence s_desel;
    FL_CS_N [*5];
  endsequence
  sequence s_pause;
    (!FL_CS_N && !FL_IO3_I && !FL_SCK) [*5];
  endsequence
  sequence s_sck_hi;
    (FL_SCK && !FL_CS_N && FL_IO3_I) [*8];
  endsequence
  sequence s_stat_rd;
    REG_RD && REG_ADDR == RA_STAT && $stable(FL_STANDBY) ##1 $stable(FL_STANDBY);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (CLK_EN && !REG_RD |=> REG_RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");
  AST_UNMAP: assert property (CLK_EN && REG_RD && REG_ADDR > RA_FLAG |=> REG_RDATA == '0)
    else $error("unmapped read not zero");
  AST_FLAG_IDLE: assert property (REG_RD && REG_ADDR == RA_FLAG && FL_STANDBY |=>
    REG_RDATA[31:8] == 24'h00_0000 && REG_RDATA[FL_PEC])
    else $error("controller flag low while idle");
  AST_STAT_STBY: assert property (s_stat_rd |-> REG_RDATA[ST_STBY] == FL_STANDBY)
    else $error("status standby bit differs from pin");
  AST_STBY_SEL: assert property (s_sel |-> !FL_STANDBY)
    else $error("standby while selected");
  AST_PAUSE_OE: assert property (s_pause |-> !FL_IO1_OE)
    else $error("output driven while paused");
  AST_IO_STABLE: assert property (s_sck_hi |-> $stable(FL_IO1_O))
    else $error("output changed while clock high");
  AST_OE_DESEL: assert property (s_desel |-> !FL_IO0_OE && !FL_IO1_OE)
    else $error("output enabled while deselected");
endmodule // sfl_flash_chk
bind sfl_flash sfl_flash_chk chk_u (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .FL_CS_N(FL_CS_N), .FL_SCK(FL_SCK), .FL_IO3_I(FL_IO3_I), .FL_IO1_O(FL_IO1_O),
  .FL_IO0_OE(FL_IO0_OE), .FL_IO1_OE(FL_IO1_OE), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .FL_STANDBY(FL_STANDBY));
`default_nettype wire

// file: sfl_flash_tb.sv
// testbench: serial flash block against a byte-array model
`timescale 1ns/100ps
`default_nettype none
module sfl_flash_tb;
  import sfl_pkg::*;
  localparam int MSZ = 1 << 14;
  logic clk, rst, en, wr, rd, tog, cs_n, sck, m_io0, m_io3, stby;
  logic [7:0] addr, b;
  logic [31:0] wdata, rdata, v;
  logic [3:0] io_o, io_oe;
  wire [3:0] io_i;
  logic [7:0] mem [0:MSZ-1];
  logic [7:0] ra [6] = '{RA_VOL_CFG, RA_NV_CFG, RA_VOL_ENH, RA_STAT, RA_FLAG, 8'h1c};
  logic [31:0] rv [6] = '{{24'h0, VOL_CFG_RST}, {16'h0, NV_CFG_RST}, {24'h0, VOL_ENH_RST},
    32'h0000_0004, 32'h0000_0080, 32'h0000_0000};
  int err_total, cmp_count, seed;
  assign io_i[0] = io_oe[0] ? io_o[0] : m_io0;
  assign io_i[1] = io_oe[1] ? io_o[1] : tog;
  assign io_i[2] = io_oe[2] ? io_o[2] : !tog;
  assign io_i[3] = io_oe[3] ? io_o[3] : m_io3;
  sfl_spi_mst m_u (.cs_n(cs_n), .sck(sck), .io0(m_io0), .io3(m_io3), .io1(io_i[1]));
  sfl_flash #(.MEM_AW(14)) dut_u (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(en),
    .FL_CS_N(cs_n), .FL_SCK(sck), .FL_IO0_I(io_i[0]), .FL_IO0_O(io_o[0]),
    .FL_IO0_OE(io_oe[0]), .FL_IO1_I(io_i[1]), .FL_IO1_O(io_o[1]), .FL_IO1_OE(io_oe[1]),
    .FL_IO2_I(io_i[2]), .FL_IO2_O(io_o[2]), .FL_IO2_OE(io_oe[2]), .FL_IO3_I(io_i[3]),
    .FL_IO3_O(io_o[3]), .FL_IO3_OE(io_oe[3]), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .FL_STANDBY(stby));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  always @(posedge clk)
    tog <= !tog;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task automatic rr(input logic [7:0] a, output logic [31:0] d);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  end
  endtask
  // eb: 1 busy expected, 0 refused, 2 not checked
  task automatic poll(input int eb);
    int n;
  begin
    // runs beside the deselect, so the first read lands while a short cycle is busy
    repeat (23) @(posedge clk);
    rr(RA_STAT, v);
    if (eb < 2)
      chk({31'h0, v[ST_BUSY]}, eb);
    for (n = 0; v[ST_BUSY] !== 1'b0; n++)
    begin
      if (n > 30000)
      begin
        err_total++;
        wrap_up;
      end
      rr(RA_STAT, v);
    end
  end
  endtask
  task automatic hdr(input logic [7:0] op, input int a);
  begin
    m_u.sel(1'b1);
    m_u.xfer(op, b);
    for (int k = 2; k >= 0; k--)
      m_u.xfer(a[8*k+:8], b);
  end
  endtask
  task automatic one(input logic [7:0] op);
  begin
    m_u.sel(1'b1);
    m_u.xfer(op, b);
    m_u.sel(1'b0);
  end
  endtask
  task automatic rdchk(input logic [7:0] op, input int a, input int n, input int dm, input int pz);
  begin
    hdr(op, a);
    m_u.clocks(dm, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      if (k == 2 && pz > 0)
        m_u.clocks(pz, 1'b0);
      m_u.xfer(8'hff, b);
      chk({24'h0, b}, {24'h0, mem[(a + k) % MSZ]});
    end
    m_u.sel(1'b0);
  end
  endtask
  task automatic prog(input int a, input int n, input logic latch, input int eb);
  begin
    if (latch)
      one(OP_WLSET);
    hdr(OP_PGW, a);
    for (int k = 0; k < n; k++)
    begin
      b = 8'($random(seed));
      if (eb == 1)
        mem[(a & ~255) | ((a + k) & 255)] &= b;
      m_u.xfer(b, v[7:0]);
    end
    fork
      m_u.sel(1'b0);
      poll(eb);
    join
  end
  endtask
  task automatic erase(input logic [7:0] op, input int a, input int sz);
  begin
    one(OP_WLSET);
    if (op == OP_EALL)
    begin
      m_u.sel(1'b1);
      m_u.xfer(op, b);
    end
    else
      hdr(op, a);
    fork
      m_u.sel(1'b0);
      poll(1);
    join
    for (int k = 0; k < sz; k++)
      mem[(a & ~(sz - 1)) + k] = 8'hff;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hf88380a5;
    {rst, en, wr, rd, tog, addr, wdata} = {5'b11000, 8'h00, 32'h0000_0000};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      rr(ra[k], v);
      chk(v, rv[k]);
    end
    $display("test reset values finished");
    one(OP_WLSET);
    rr(RA_STAT, v);
    chk(v, 32'h0000_0006);
    erase(OP_EALL, 0, MSZ);
    rr(RA_FLAG, v);
    chk(v, 32'h0000_0080);
    prog(32'h1f0, 20, 1'b1, 1);
    rdchk(OP_READ, 32'h1f0, 20, 0, 0);
    rdchk(OP_FREAD, 32'h100, 4, 8, 3);
    rw(RA_VOL_CFG, 32'h0000_003b);
    rdchk(OP_FREAD, 32'h1f0, 4, 3, 0);
    rw(RA_NV_CFG, 32'h0000_5fff);
    rw(RA_VOL_CFG, 32'h0000_000b);
    rdchk(OP_FREAD, 32'h1f0, 4, 5, 0);
    $display("test program and read finished");
    prog(32'h1f0, 4, 1'b0, 0);
    rdchk(OP_READ, 32'h1f0, 4, 0, 0);
    rw(RA_LOCK, 32'h0000_0001);
    prog(32'h0, 4, 1'b1, 2);
    rr(RA_FLAG, v);
    chk(v, 32'h0000_0090);
    rw(RA_FLAG, 32'h0000_0010);
    rr(RA_FLAG, v);
    chk(v, 32'h0000_0080);
    rdchk(OP_READ, 32'h0, 4, 0, 0);
    rw(RA_CTRL, 32'h0000_0001);
    m_u.rst_pulse();
    rr(RA_LOCK, v);
    chk(v, 32'h0000_0000);
    en <= 1'b0;
    rw(RA_LOCK, 32'h0000_0002);
    en <= 1'b1;
    rr(RA_LOCK, v);
    chk(v, 32'h0000_0000);
    rw(RA_CTRL, 32'h0000_0000);
    $display("test lock and pin reset finished");
    erase(OP_ESMALL, 32'h100, 1024);
    rdchk(OP_READ, 32'h1f0, 4, 0, 0);
    prog(32'h1f0, 4, 1'b1, 1);
    erase(OP_EBLK, 32'h0, 4096);
    rdchk(OP_READ, 32'h1f0, 4, 0, 0);
    repeat (10) @(posedge clk);
    chk({31'h0, stby}, 32'h0000_0001);
    $display("test erases finished");
    wrap_up;
  end
endmodule // sfl_flash_tb
`default_nettype wire

// file: sfl_pkg.sv
// package: constants, opcodes, register map and states of the serial flash block
package sfl_pkg;
  // timing
  localparam int CLK_NS = 4;
  localparam int RST_SEL_NS = 100;
  localparam int RST_SEL_CYC = (RST_SEL_NS + CLK_NS - 1) / CLK_NS;
  // single-line instruction opcodes
  localparam logic [7:0] OP_WLSET = 8'h06;
  localparam logic [7:0] OP_WLCLR = 8'h04;
  localparam logic [7:0] OP_RSTAT = 8'h05;
  localparam logic [7:0] OP_RFLAG = 8'h70;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_DOREAD = 8'h3b;
  localparam logic [7:0] OP_DIOREAD = 8'hbb;
  localparam logic [7:0] OP_QOREAD = 8'h6b;
  localparam logic [7:0] OP_QIOREAD = 8'heb;
  localparam logic [7:0] OP_PGW = 8'h02;
  localparam logic [7:0] OP_P2D = 8'ha2;
  localparam logic [7:0] OP_P2AD = 8'hd2;
  localparam logic [7:0] OP_P4D = 8'h32;
  localparam logic [7:0] OP_P4AD = 8'h12;
  localparam logic [7:0] OP_ESMALL = 8'h20;
  localparam logic [7:0] OP_EBLK = 8'hd8;
  localparam logic [7:0] OP_EALL = 8'hc7;
  // register port
  localparam int RA_W = 8;
  localparam logic [7:0] RA_VOL_CFG = 8'h00;
  localparam logic [7:0] RA_NV_CFG = 8'h04;
  localparam logic [7:0] RA_VOL_ENH = 8'h08;
  localparam logic [7:0] RA_CTRL = 8'h0c;
  localparam logic [7:0] RA_LOCK = 8'h10;
  localparam logic [7:0] RA_STAT = 8'h14;
  localparam logic [7:0] RA_FLAG = 8'h18;
  // fields
  localparam int VOL_DUMMY_LO = 4;
  localparam int NV_DUMMY_LO = 12;
  localparam int ENH_PIN_EN = 4;
  localparam int CTRL_RSTFN = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_WLATCH = 1;
  localparam int ST_STBY = 2;
  localparam int FL_PEC = 7;
  localparam int FL_EERR = 5;
  localparam int FL_PERR = 4;
  // reset values
  localparam logic [7:0] VOL_CFG_RST = 8'hfb;
  localparam logic [15:0] NV_CFG_RST = 16'hffff;
  localparam logic [7:0] VOL_ENH_RST = 8'hff;
  localparam logic [5:0] PIN_RST = 6'h01;
  localparam logic [3:0] DUMMY_DEF = 4'h8;
  // geometry
  localparam int PAGE_BYTES = 256;
  localparam int BOOT_SECS = 8;
  localparam int ADDR_BITS = 24;
  typedef enum logic [5:0] {
    ST_CMD = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_DUMMY = 6'b000100,
    ST_DIN = 6'b001000,
    ST_DOUT = 6'b010000,
    ST_IGN = 6'b100000
  } sfl_state_t;
  typedef enum logic [2:0] {
    CY_IDLE = 3'b001,
    CY_PROG = 3'b010,
    CY_ERASE = 3'b100
  } sfl_cycle_t;
endpackage

// file: sfl_spi_mst.sv
// spi bus master model, mode 0, single-line frames
`timescale 1ns/100ps
`default_nettype none
module sfl_spi_mst (
  output logic cs_n,
  output logic sck,
  output logic io0,
  output logic io3,
  input wire logic io1
);
  localparam int HALF = 80;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    io0 = 1'b0;
    io3 = 1'b1;
  end
  task automatic sel(input logic on);
  begin
    #(HALF);
    cs_n = !on;
    // released line shows the inverse, not a stale bit
    io0 = !io0;
    #(HALF);
  end
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
  begin
    for (int i = 7; i >= 0; i--)
    begin
      io0 = tx[i];
      #(HALF);
      sck = 1'b1;
      rx[i] = io1;
      #(HALF);
      sck = 1'b0;
    end
  end
  endtask
  // hold low gives a pause with junk clocks, high gives dummy clocks
  task automatic clocks(input int n, input logic hold);
  begin
    io3 = hold;
    repeat (n)
    begin
      #(HALF);
      sck = 1'b1;
      io0 = !io0;
      #(HALF);
      sck = 1'b0;
    end
    #(HALF);
    io3 = 1'b1;
  end
  endtask
  task automatic rst_pulse;
  begin
    io3 = 1'b0;
    #(200);
    io3 = 1'b1;
    #(400);
  end
  endtask
endmodule // sfl_spi_mst
`default_nettype wire
